//--- twe_pkg.sv
// shared constants and types for the two-wire eeprom target
package twe_pkg;
    localparam int unsigned ADDR_W = 15;
    localparam int unsigned PAGE_W = 6;
    localparam int unsigned MEM_WORDS = 32768;
    localparam int unsigned PAGE_COUNT = 512;
    localparam int unsigned FIFO_DEPTH = 32;
    localparam int unsigned FIFO_AW = 5;
    localparam logic [3:0] DEV_CLASS = 4'ha;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 15'h0000;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned WRITE_TIME_MS = 5;
    localparam int unsigned WRITE_CYCLES = WRITE_TIME_MS * 1000 * CLK_MHZ;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;

    typedef enum logic [2:0] {
        TWE_IDLE = 3'b000,
        TWE_DEVADDR = 3'b001,
        TWE_ADDR_HI = 3'b011,
        TWE_ADDR_LO = 3'b010,
        TWE_WDATA = 3'b110,
        TWE_RDATA = 3'b111,
        TWE_RACK = 3'b101,
        TWE_BUSY = 3'b100
    } twe_state_t;
endpackage

//--- twe_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module twe_sync
    import twe_pkg::*;
#(
    parameter int unsigned W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;

    // first stage is read only by the second
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= '1;
            dout <= '1;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule

//--- twe_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module twe_fifo
    import twe_pkg::*;
#(
    parameter int unsigned WIDTH = 23,
    parameter int unsigned DEPTH = FIFO_DEPTH,
    parameter int unsigned AW = FIFO_AW
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    // accept while fewer than depth words are held; an empty fifo must accept
    assign in_ready = (cnt_q < (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // storage and pointers
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

//--- twe_target.sv
// two-wire serial eeprom target: protocol engine, array and write cycle
// Operation
// R01 - sda changes with scl high are start or stop, never data
// R02 - sda falling with scl high is start, seen in any state; the code ignores it in TWE_BUSY
// R03 - sda rising with scl high is stop; stop after read gives standby
// R04 - words are 8 bits msb first; device pulls sda low on ninth clock
// R05 - standby after reset and after stop once internal work finishes
// R06 - start, nine clocks, start, stop leaves device ready
// R07 - device address word starts with fixed pattern 1010
// R08 - next three bits must match the three chip-select straps
// R09 - floating strap counts as low
// R10 - eighth address bit: 1 read, 0 write
// R11 - match acknowledges; mismatch no acknowledge, standby until start
// R12 - write-protect high protects the whole array
// R13 - byte write: device address, two address bytes, one data byte, stop
// R14 - stop after write data starts the self-timed write cycle
// R15 - during write cycle inputs ignored and no bus response
// R16 - page write takes up to 64 bytes, each acknowledged; the fifo holds only 32 (FIFO_DEPTH), later bytes are acked but dropped
// R17 - writes increment only low six address bits, wrapping in page
// R18 - polling: acknowledge only after internal write has finished
// R19 - address counter keeps last address plus one, reads wrap to zero
// R20 - current read returns byte at counter; host nacks and stops
// R21 - random read loads address by dataless write, then repeated start
// R22 - acked read byte advances to next byte; nack and stop end read
// R23 - array is 512 pages of 64 bytes
// R24 - word address is 15 bits; top bit of first byte ignored
// R25 - with write-protect, bytes acknowledged but no write, no write cycle
// R26 - write cycle length is a parameter in clock cycles
`timescale 1ns/1ps
module twe_target
    import twe_pkg::*;
#(
    parameter int unsigned INTERNAL_WRITE_TIME = WRITE_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic chip_select_strap_2,
    input wire logic chip_select_strap_1,
    input wire logic chip_select_strap_0,
    input wire logic write_protect,
    output logic standby,
    output logic write_busy
);
    localparam int unsigned FW = ADDR_W + 8;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisation and edge detection
    logic [5:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic scl_prev_q;
    logic sda_prev_q;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic [2:0] straps;
    logic wp_s;

    twe_sync #(.W(6)) u_sync (
        .clk(clk),
        .rst(rst),
        .din({scl, sda_in, chip_select_strap_2, chip_select_strap_1,
              chip_select_strap_0, write_protect}),
        .dout(pins_s)
    );

    assign scl_s = pins_s[5];
    assign sda_s = pins_s[4];
    // an undriven strap resolves to x or z in the bench; treat it as low
    assign straps = {pins_s[3] === 1'b1, pins_s[2] === 1'b1, pins_s[1] === 1'b1}; // R09
    assign wp_s = pins_s[0];

    always_ff @(posedge clk) begin
        if (rst) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    assign scl_rise = scl_s && !scl_prev_q;
    assign scl_fall = !scl_s && scl_prev_q;
    // sda edges while scl stays high are framing, not data
    assign start_det = scl_s && scl_prev_q && sda_prev_q && !sda_s; // R01 R02
    assign stop_det = scl_s && scl_prev_q && !sda_prev_q && sda_s; // R01 R03

    ////////////////////////////////////////////////////////////////////////
    // state and shift registers
    twe_state_t state_q;
    logic [3:0] bit_q;
    logic [7:0] shift_q;
    logic [ADDR_W-1:0] addr_q;
    logic [7:0] addr_hi_q;
    logic ack_phase_q;
    logic ack_due_q;
    logic drive_low_q;
    logic [7:0] tx_q;
    logic got_data_q;
    logic [31:0] wcnt_q;
    logic [7:0] mem [MEM_WORDS];
    logic byte_done;
    logic dev_match;

    // low six bits advance, upper nine hold the page
    function automatic logic [ADDR_W-1:0] page_inc(input logic [ADDR_W-1:0] a);
        page_inc = {a[ADDR_W-1:PAGE_W], a[PAGE_W-1:0] + 6'h01}; // R17 R23
    endfunction

    // full-array increment wraps from last byte to zero
    function automatic logic [ADDR_W-1:0] lin_inc(input logic [ADDR_W-1:0] a);
        lin_inc = a + 15'h0001; // R19 R22
    endfunction

    // eighth data bit is sampled on this rise
    assign byte_done = scl_rise && !ack_phase_q && (bit_q == BIT_LAST);
    assign dev_match = ({shift_q[6:0], sda_s} >> 4) == {4'h0, DEV_CLASS} // R07
                       && shift_q[2:0] == straps; // R08

    ////////////////////////////////////////////////////////////////////////
    // fifo between the serial receiver and the array writer
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [FW-1:0] fifo_in_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [FW-1:0] fifo_out_data;
    logic commit_q;

    twe_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // up to 32 bytes (FIFO_DEPTH) of a page are staged here and only programmed once the stop commits them;
    // the drain stalls until then, so the fifo really fills
    assign fifo_out_ready = commit_q;

    ////////////////////////////////////////////////////////////////////////
    // bit counter and ack phase
    always_ff @(posedge clk) begin
        if (rst) begin
            bit_q <= '0;
            ack_phase_q <= 1'b0;
        end else if (start_det || state_q == TWE_IDLE || state_q == TWE_BUSY) begin
            bit_q <= '0;
            ack_phase_q <= 1'b0;
        end else if (scl_rise) begin
            if (ack_phase_q) begin
                ack_phase_q <= 1'b0;
                bit_q <= '0;
            end else if (bit_q == BIT_LAST) begin
                ack_phase_q <= 1'b1; // R04
            end else begin
                bit_q <= bit_q + 4'h1;
            end
        end
    end

    // receive shifter, msb first on scl rise
    always_ff @(posedge clk) begin
        if (rst) begin
            shift_q <= '0;
        end else if (scl_rise && !ack_phase_q) begin
            shift_q <= {shift_q[6:0], sda_s}; // R04
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // protocol state machine
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= TWE_IDLE; // R05
            got_data_q <= 1'b0;
            addr_hi_q <= '0;
        end else if (state_q == TWE_BUSY) begin
            // inputs ignored until the write cycle ends
            if (wcnt_q == 32'h0 && !fifo_out_valid && !commit_q) begin
                state_q <= TWE_IDLE; // R15 R05
            end
        end else if (start_det) begin
            state_q <= TWE_DEVADDR; // R02 R06
            got_data_q <= 1'b0;
        end else if (stop_det) begin
            // stop commits staged data or drops to standby
            state_q <= (got_data_q && !wp_s) ? TWE_BUSY : TWE_IDLE; // R03 R14 R25
            got_data_q <= 1'b0;
        end else if (byte_done) begin
            case (state_q)
                TWE_DEVADDR: begin
                    if (dev_match) begin
                        state_q <= sda_s ? TWE_RDATA : TWE_ADDR_HI; // R10
                    end else begin
                        state_q <= TWE_IDLE; // R11
                    end
                end
                TWE_ADDR_HI: begin
                    addr_hi_q <= {shift_q[6:0], sda_s};
                    state_q <= TWE_ADDR_LO; // R13
                end
                TWE_ADDR_LO: begin
                    state_q <= TWE_WDATA; // R21
                end
                TWE_WDATA: begin
                    got_data_q <= 1'b1; // R16
                end
                TWE_RDATA: begin
                    state_q <= TWE_RACK;
                end
                default: begin
                    state_q <= state_q;
                end
            endcase
        end else if (state_q == TWE_RACK && scl_rise) begin
            // host ack continues, nack drops straight to idle
            state_q <= sda_s ? TWE_IDLE : TWE_RDATA; // R22 R20
        end
    end

    // address counter, staging writes and advancing reads
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_q <= ADDR_RESET; // R19
        end else if (byte_done && state_q == TWE_ADDR_LO) begin
            addr_q <= {addr_hi_q[6:0], shift_q[6:0], sda_s}; // R24
        end else if (byte_done && state_q == TWE_WDATA) begin
            addr_q <= page_inc(addr_q); // R17
        end else if (byte_done && state_q == TWE_RDATA) begin
            addr_q <= lin_inc(addr_q); // R19 R22
        end
    end

    assign fifo_in_valid = byte_done && state_q == TWE_WDATA && !wp_s; // R12 R25
    assign fifo_in_data = {addr_q, shift_q[6:0], sda_s};

    ////////////////////////////////////////////////////////////////////////
    // internal write cycle: timer and array programming
    always_ff @(posedge clk) begin
        if (rst) begin
            wcnt_q <= '0;
            commit_q <= 1'b0;
        end else if (state_q != TWE_BUSY && stop_det && got_data_q && !wp_s) begin
            wcnt_q <= INTERNAL_WRITE_TIME - 1; // R14 R26
            commit_q <= 1'b1;
        end else begin
            if (wcnt_q != 32'h0) begin
                wcnt_q <= wcnt_q - 32'h1; // R26
            end
            if (!fifo_out_valid) begin
                commit_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (fifo_out_valid && fifo_out_ready) begin
            mem[fifo_out_data[FW-1:8]] <= fifo_out_data[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // acknowledge owed for the word that just ended; read bytes are acked by the host
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_due_q <= 1'b0;
        end else if (byte_done) begin
            ack_due_q <= (state_q == TWE_DEVADDR && dev_match) // R11
                         || state_q == TWE_ADDR_HI || state_q == TWE_ADDR_LO
                         || state_q == TWE_WDATA; // R04
        end
    end

    // sda driver: ack and read data change only after scl has fallen
    always_ff @(posedge clk) begin
        if (rst) begin
            drive_low_q <= 1'b0;
        end else if (state_q == TWE_BUSY || start_det || stop_det) begin
            drive_low_q <= 1'b0; // R15 R18
        end else if (scl_fall) begin
            if (ack_phase_q) begin
                drive_low_q <= ack_due_q; // R04 R11
            end else if (state_q == TWE_RDATA) begin
                drive_low_q <= !tx_q[3'(BIT_LAST - bit_q)]; // R20 R22
            end else begin
                drive_low_q <= 1'b0;
            end
        end
    end

    // next read byte fetched during the ack clock, so its first bit is ready at the fall
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_q <= 8'hff;
        end else if (ack_phase_q && (state_q == TWE_RDATA || state_q == TWE_RACK)) begin
            tx_q <= mem[addr_q]; // R20 R22
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = drive_low_q;
    assign standby = (state_q == TWE_IDLE); // R05
    assign write_busy = (state_q == TWE_BUSY); // R15
endmodule

//--- twe_chk.sv
// concurrent checks on the pins of the two-wire eeprom target
`timescale 1ns/1ps
module twe_chk
    import twe_pkg::*;
#(
    parameter int unsigned INTERNAL_WRITE_TIME = WRITE_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic chip_select_strap_2,
    input wire logic chip_select_strap_1,
    input wire logic chip_select_strap_0,
    input wire logic write_protect,
    input wire logic standby,
    input wire logic write_busy
);
    logic [31:0] busy_cnt_q;
    ////////////////////////////////////////////////////////////////////////////////
    // length of the running write cycle, cleared whenever it is not running
    always_ff @(posedge clk) begin
        if (rst || !write_busy) begin
            busy_cnt_q <= 32'h0;
        end else begin
            busy_cnt_q <= busy_cnt_q + 32'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // scl must already be high one cycle, so a data change is never taken for these
    sequence start_seen;
        scl && $past(scl) && $fell(sda_in);
    endsequence
    sequence stop_seen;
        scl && $past(scl) && $rose(sda_in);
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    reset_idle_a: assert property ($fell(rst) |-> standby && !write_busy && !sda_oe)
        else $error("outputs not idle after reset");
    drive_low_a: assert property (sda_oe |-> sda_out == 1'b0)
        else $error("data line driven high");
    sda_stable_a: assert property ($changed(sda_oe) |-> !scl)
        else $error("data drive changed while scl high");
    busy_quiet_a: assert property (write_busy |-> !sda_oe)
        else $error("bus answered during write cycle");
    busy_not_idle_a: assert property (write_busy |-> !standby)
        else $error("standby while write cycle runs");
    busy_length_a: assert property ($fell(write_busy) |-> busy_cnt_q == INTERNAL_WRITE_TIME)
        else $error("write cycle length wrong");
    stop_idle_a: assert property (stop_seen |-> ##[1:8] (standby || write_busy))
        else $error("no standby or write cycle after stop");
    start_wake_a: assert property (start_seen and !write_busy |-> ##[1:8] !standby)
        else $error("start not taken");
    protect_nowrite_a: assert property (stop_seen and write_protect |-> ##1 !write_busy [*8])
        else $error("write cycle under write protect");
endmodule
bind twe_target twe_chk #(.INTERNAL_WRITE_TIME(INTERNAL_WRITE_TIME)) u_chk (
    .clk(clk), .rst(rst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .chip_select_strap_2(chip_select_strap_2), .chip_select_strap_1(chip_select_strap_1),
    .chip_select_strap_0(chip_select_strap_0), .write_protect(write_protect),
    .standby(standby), .write_busy(write_busy));

//--- twe_host.sv
// bus controller model driving scl and the shared data line
`timescale 1ns/1ps
module twe_host (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_rel
);
    // line released and scl high at time zero; scl stands still between frames
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    // a quarter of the 160 ns bus period; all changes on falling clk
    task automatic q();
        repeat (4) @(negedge clk);
    endtask
    // data set only while scl is low and held over the high phase
    task automatic bit_tx(input logic b);
        sda_rel = b;
        q();
        scl = 1'b1;
        q();
        q();
        scl = 1'b0;
        q();
    endtask
    task automatic bit_rx(output logic b);
        sda_rel = 1'b1;
        q();
        scl = 1'b1;
        q();
        b = sda;
        q();
        scl = 1'b0;
        q();
    endtask
    task automatic start();
        sda_rel = 1'b1;
        q();
        scl = 1'b1;
        q();
        sda_rel = 1'b0;
        q();
        scl = 1'b0;
        q();
    endtask
    task automatic stop();
        sda_rel = 1'b0;
        q();
        scl = 1'b1;
        q();
        sda_rel = 1'b1;
        q();
    endtask
    // msb first, then the ninth clock samples the answer
    task automatic wr(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) bit_tx(b[i]);
        bit_rx(ack);
    endtask
    // host answers 0 to continue, 1 to end a read
    task automatic rd(input logic more, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) bit_rx(b[i]);
        bit_tx(!more);
    endtask
    task automatic clocks(input int n);
        logic d;
        repeat (n) bit_rx(d);
    endtask
endmodule

//--- testbench.sv
// self-checking bench for the two-wire eeprom target
`timescale 1ns/1ps
module testbench;
    import twe_pkg::*;
    logic clk, rst, write_protect, sda_oe, sda_out, standby, write_busy, scl, sda_rel;
    logic [2:0] straps;
    wire logic sda;
    int failures = 0;
    int n_compared = 0;
    // pull-up on the wire; either party may pull it low
    assign sda = sda_rel & ~(sda_oe & ~sda_out);
    twe_host u_host (.clk(clk), .sda(sda), .scl(scl), .sda_rel(sda_rel));
    twe_target #(.INTERNAL_WRITE_TIME(200)) u_dut (.clk(clk), .rst(rst), .scl(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_strap_2(straps[2]),
        .chip_select_strap_1(straps[1]), .chip_select_strap_0(straps[0]),
        .write_protect(write_protect), .standby(standby), .write_busy(write_busy));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk1(input logic g, input logic e);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("ERROR %0t flag %b expected %b", $time, g, e);
        end
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("ERROR %0t byte %h expected %h", $time, g, e);
        end
    endtask
    // bounded wait for the write cycle to end; a hang ends the run
    task automatic wait_free();
        int n;
        n = 0;
        while (write_busy !== 1'b0 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        if (write_busy !== 1'b0) begin
            failures++;
            $display("ERROR %0t write cycle never ended", $time);
            tally_and_finish();
        end
    endtask
    task automatic idle_chk();
        repeat (4) @(negedge clk);
        chk1(standby, 1'b1);
    endtask
    task automatic addr_wr(input logic [7:0] hi, input logic [7:0] lo);
        logic a;
        u_host.start();
        u_host.wr(8'haa, a);
        chk1(a, 1'b0);
        u_host.wr(hi, a);
        chk1(a, 1'b0);
        u_host.wr(lo, a);
        chk1(a, 1'b0);
    endtask
    // dataless write, repeated start, then n bytes with host acks between
    task automatic rd_at(input logic [7:0] hi, input logic [7:0] lo, input int n,
        input logic [7:0] first);
        logic a;
        logic [7:0] d;
        addr_wr(hi, lo);
        u_host.start();
        u_host.wr(8'hab, a);
        chk1(a, 1'b0);
        for (int i = 0; i < n; i++) begin
            u_host.rd(i < n - 1, d);
            chk8(d, first + 8'(i));
        end
        u_host.stop();
        idle_chk();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // four bytes from the top of a page wrap to its start; polls during the cycle
    task automatic t_page();
        logic a;
        addr_wr(8'h81, 8'h3e);
        for (int i = 0; i < 4; i++) begin
            u_host.wr(8'h10 + 8'(i), a);
            chk1(a, 1'b0);
        end
        u_host.stop();
        repeat (8) @(negedge clk);
        chk1(write_busy, 1'b1);
        u_host.start();
        u_host.wr(8'hab, a);
        chk1(a, 1'b1);
        u_host.stop();
        wait_free();
        u_host.start();
        u_host.wr(8'haa, a);
        chk1(a, 1'b0);
        u_host.stop();
        rd_at(8'h01, 8'h3e, 2, 8'h10);
        rd_at(8'h01, 8'h00, 2, 8'h12);
        $display("page write done");
    endtask
    // single read leaves the counter one past; current read follows it
    task automatic t_current();
        logic a;
        logic [7:0] d;
        rd_at(8'h01, 8'h3e, 1, 8'h10);
        u_host.start();
        u_host.wr(8'hab, a);
        chk1(a, 1'b0);
        u_host.rd(1'b0, d);
        chk8(d, 8'h11);
        u_host.stop();
        idle_chk();
        $display("current read done");
    endtask
    // protected write is acknowledged but neither busies nor changes the array
    task automatic t_protect();
        logic a;
        write_protect = 1'b1;
        addr_wr(8'h01, 8'h3e);
        u_host.wr(8'h55, a);
        chk1(a, 1'b0);
        u_host.stop();
        repeat (8) @(negedge clk);
        chk1(write_busy, 1'b0);
        write_protect = 1'b0;
        rd_at(8'h01, 8'h3e, 1, 8'h10);
        $display("protect done");
    endtask
    // wrong strap bits, floating straps, then the recovery sequence
    task automatic t_select();
        logic a;
        logic [7:0] d;
        u_host.start();
        u_host.wr(8'ha3, a);
        chk1(a, 1'b1);
        repeat (8) @(negedge clk);
        chk1(standby, 1'b1);
        u_host.stop();
        straps = 3'bzzz;
        u_host.start();
        u_host.wr(8'ha1, a);
        chk1(a, 1'b0);
        u_host.rd(1'b0, d);
        chk8(d, 8'h11);
        u_host.stop();
        straps = 3'b101;
        u_host.start();
        u_host.clocks(9);
        u_host.start();
        u_host.stop();
        rd_at(8'h01, 8'h3e, 1, 8'h10);
        $display("select and recovery done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        write_protect = 1'b0;
        straps = 3'b101;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk1(standby, 1'b1);
        chk1(write_busy, 1'b0);
        chk1(sda_oe, 1'b0);
        t_page();
        t_current();
        t_protect();
        t_select();
        tally_and_finish();
    end
endmodule
